// [pca_defs.svh]
/*
 * constants of the pulse count accumulator: clock rate, times, register
 * offsets and field positions.
 * assumes: included by bare name from every design file that needs it.
 */
`ifndef PCA_DEFS_SVH
`define PCA_DEFS_SVH

// clock and times, each in its own unit
`define PCA_CLK_HZ           25000000
`define PCA_MS_PER_S         1000
`define PCA_SW_CLOSE_MIN_MS  5
`define PCA_SW_OPEN_MIN_MS   6
`define PCA_BOUNCE_MAX_MS    1
`define PCA_DRAIN_FAST_HZ    64
`define PCA_DRAIN_SLOW_HZ    8

// counter widths
`define PCA_DB_W             18
`define PCA_DRAIN_W          19
`define PCA_DIV_W            3

// register byte offsets
`define PCA_REG_CFG0         6'h00
`define PCA_REG_CFG1         6'h04
`define PCA_REG_MULT0        6'h08
`define PCA_REG_MULT1        6'h0c
`define PCA_REG_OFFS0        6'h10
`define PCA_REG_OFFS1        6'h14
`define PCA_REG_INTERVAL     6'h18
`define PCA_REG_STATUS       6'h1c
`define PCA_REG_SNAP0        6'h20
`define PCA_REG_SNAP1        6'h24
`define PCA_REG_ACC0         6'h28
`define PCA_REG_ACC1         6'h2c
`define PCA_REG_RESULT       6'h30

// configuration fields
`define PCA_F_TYPE           2:0
`define PCA_F_OPT            4:3
`define PCA_F_INDEX          5
`define PCA_F_SRC            7:6
`define PCA_F_LOC            15:8

// status fields
`define PCA_ST_OVF0          0
`define PCA_ST_OVF1          1
`define PCA_ST_BUSY          2
`define PCA_ST_CHAIN         3

// reset values
`define PCA_CFG_RST          32'h0000_0000
`define PCA_MULT_RST         16'h0001
`define PCA_OFFS_RST         32'h0000_0000
`define PCA_INTERVAL_RST     16'h0001

`endif

// [pca_pkg.sv]
/*
 * types of the pulse count accumulator: input types, options, sources and
 * the scaling state machine.
 * assumes: compiled before every module that imports it.
 */
package pca_pkg;

   typedef enum logic [2:0] {
      PT_HF   = 3'b000,
      PT_AC   = 3'b001,
      PT_SW   = 3'b010,
      PT_HF16 = 3'b011,
      PT_AC16 = 3'b100
   } pca_type_t;

   typedef enum logic [1:0] {
      OPT_NONE    = 2'b00,
      OPT_DISCARD = 2'b01,
      OPT_FREQ    = 2'b10
   } pca_opt_t;

   typedef enum logic [1:0] {
      SRC_OWN_PIN     = 2'b00,
      SRC_CTRL_ONE    = 2'b01,
      SRC_SHARED_PORT = 2'b10
   } pca_src_t;

   typedef enum logic [1:0] {
      SC_IDLE = 2'b00,
      SC_DIV  = 2'b01,
      SC_MAC  = 2'b10
   } pca_sc_state_t;

endpackage : pca_pkg

// [pca_debounce.sv]
/*
 * switch closure qualifier for one input pin: the closed or open state is
 * taken only after the pin has held it for a set number of cycles.
 * assumes: i_pin synchronous to i_clk; qualifying counts below 2**18.
 */
`timescale 1ns/1ns
`include "pca_defs.svh"

module pca_debounce import pca_pkg::*; #(
   parameter logic        ACTIVE_CLOSED = 1'b0,
   parameter int unsigned CLOSE_QUAL    = 2,
   parameter int unsigned OPEN_QUAL     = 2
) (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   // pin
   input  wire logic i_pin,
   // qualified events
   output logic      o_open_evt,
   output logic      o_close_evt
);

   localparam logic [`PCA_DB_W-1:0] CLOSE_LIM = 18'(CLOSE_QUAL - 1);
   localparam logic [`PCA_DB_W-1:0] OPEN_LIM  = 18'(OPEN_QUAL - 1);

   logic                 closed_r,    closed_nxt;
   logic [`PCA_DB_W-1:0] cnt_r,       cnt_nxt;
   logic                 open_evt_r,  open_evt_nxt;
   logic                 close_evt_r, close_evt_nxt;

   // a short excursion resets the run, so bounces never flip the state
   always_comb begin
      closed_nxt    = closed_r;
      cnt_nxt       = '0;
      open_evt_nxt  = 1'b0;
      close_evt_nxt = 1'b0;
      if ((i_pin == ACTIVE_CLOSED) != closed_r) begin
         if (cnt_r == (closed_r ? OPEN_LIM : CLOSE_LIM)) begin
            closed_nxt    = ~closed_r;
            open_evt_nxt  = closed_r;
            close_evt_nxt = ~closed_r;
         end else begin
            cnt_nxt = 18'(cnt_r + 1'b1);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         closed_r    <= 1'b0;
         cnt_r       <= '0;
         open_evt_r  <= 1'b0;
         close_evt_r <= 1'b0;
      end else begin
         closed_r    <= closed_nxt;
         cnt_r       <= cnt_nxt;
         open_evt_r  <= open_evt_nxt;
         close_evt_r <= close_evt_nxt;
      end
   end

   assign o_open_evt  = open_evt_r;
   assign o_close_evt = close_evt_r;

endmodule : pca_debounce

// [pca_scale.sv]
/*
 * result engine: optional division of the count by the table interval,
 * then count times multiplier plus offset.
 * assumes: i_interval, i_mult and i_offset stay steady while o_busy is high.
 */
`timescale 1ns/1ns
`include "pca_defs.svh"

module pca_scale import pca_pkg::*; (
   // clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_rst_b,
   // request
   input  wire logic               i_start,
   input  wire logic        [15:0] i_count,
   input  wire logic               i_freq,
   input  wire logic        [15:0] i_interval,
   input  wire logic signed [15:0] i_mult,
   input  wire logic signed [31:0] i_offset,
   // answer
   output logic                    o_busy,
   output logic                    o_done,
   output logic             [31:0] o_result
);

   pca_sc_state_t      state_r,  state_nxt;
   logic        [15:0] q_r,      q_nxt;
   logic        [15:0] rem_r,    rem_nxt;
   logic         [3:0] bit_r,    bit_nxt;
   logic               done_r,   done_nxt;
   logic        [31:0] result_r, result_nxt;
   logic        [16:0] trial;
   logic signed [32:0] prod;

   // serial divide keeps the area small; a result costs 18 cycles in hertz mode
   always_comb begin
      state_nxt  = state_r;
      q_nxt      = q_r;
      rem_nxt    = rem_r;
      bit_nxt    = bit_r;
      done_nxt   = 1'b0;
      result_nxt = result_r;
      trial      = {rem_r, q_r[15]};
      prod       = $signed({1'b0, q_r}) * i_mult;
      case (state_r)
         SC_IDLE: begin
            if (i_start) begin
               q_nxt     = i_count;
               rem_nxt   = '0;
               bit_nxt   = '0;
               state_nxt = (i_freq && (i_interval != '0)) ? SC_DIV : SC_MAC;
            end
         end
         SC_DIV: begin
            if (trial >= {1'b0, i_interval}) begin
               rem_nxt = 16'(trial - {1'b0, i_interval});
               q_nxt   = {q_r[14:0], 1'b1};
            end else begin
               rem_nxt = trial[15:0];
               q_nxt   = {q_r[14:0], 1'b0};
            end
            bit_nxt = 4'(bit_r + 1'b1);
            if (bit_r == '1) begin
               state_nxt = SC_MAC;
            end
         end
         SC_MAC: begin
            result_nxt = prod[31:0] + i_offset;
            done_nxt   = 1'b1;
            state_nxt  = SC_IDLE;
         end
         default: begin
            state_nxt = SC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         state_r  <= SC_IDLE;
         q_r      <= '0;
         rem_r    <= '0;
         bit_r    <= '0;
         done_r   <= 1'b0;
         result_r <= '0;
      end else begin
         state_r  <= state_nxt;
         q_r      <= q_nxt;
         rem_r    <= rem_nxt;
         bit_r    <= bit_nxt;
         done_r   <= done_nxt;
         result_r <= result_nxt;
      end
   end

   assign o_busy   = (state_r != SC_IDLE);
   assign o_done   = done_r;
   assign o_result = result_r;

endmodule : pca_scale

// [pca_top.sv]
/*
 * two channel pulse counter with 8/16-bit hardware counters, periodic drain
 * into 16-bit accumulators, per table snapshot and scaled result.
 * assumes: all inputs synchronous to I_REF_CLK; table engine pulses start
 * and instruction strobes for one cycle; Avalon-MM master with waitrequest.
 */
// Added by the designer: the Avalon-MM slave port and the register offsets.
// Function
// - switch closure on pulse pin, bounce filtered
// - pulse pin switch counts on opening
// - control ports count slow switch closures
// - control port switch counts on closing
// - shared port high blocks quiescent state; here only with I_SHARED_PORT_IRQ_EN or a channel on the shared port
// - two channels, 8-bit counters, 255 max
// - 16-bit option chains counters on channel 1
// - every 125 ms drain counters into accumulators
// - table start snapshots then clears accumulator
// - result is snapshot times multiplier plus offset
// - snapshot overwritten on every table execution; here kept on a long interval with option discard or frequency
// - discard keeps previous snapshot after long interval
// - frequency option divides by interval seconds
// - code selects input type zero to four
// - index option drains at 64 Hz; here only for types PT_HF and PT_AC, the others stay at 8 Hz
// - one snapshot store per repetition
// - 8-bit up to 2000 Hz, 16-bit 250 kHz
`timescale 1ns/1ns
`include "pca_defs.svh"

module pca_top import pca_pkg::*; #(
   parameter int unsigned BOUNCE_CYC     = `PCA_CLK_HZ / `PCA_MS_PER_S * `PCA_BOUNCE_MAX_MS,
   parameter int unsigned DRAIN_FAST_CYC = `PCA_CLK_HZ / `PCA_DRAIN_FAST_HZ
) (
   // clock and reset
   input  wire logic        I_REF_CLK,
   input  wire logic        I_RST_B,
   // avalon-mm slave
   input  wire logic  [5:0] I_AVS_ADDRESS,
   input  wire logic        I_AVS_READ,
   input  wire logic        I_AVS_WRITE,
   input  wire logic [31:0] I_AVS_WRITEDATA,
   input  wire logic  [3:0] I_AVS_BYTEENABLE,
   output logic      [31:0] O_AVS_READDATA,
   output logic             O_AVS_WAITREQUEST,
   // input pins
   input  wire logic        I_PULSE_IN1,
   input  wire logic        I_PULSE_IN2,
   input  wire logic        I_CONTROL_PORT_ONE,
   input  wire logic        I_SHARED_CONTROL_PULSE_PORT,
   input  wire logic        I_SHARED_PORT_IRQ_EN,
   // table engine
   input  wire logic        I_TABLE_START,
   input  wire logic        I_LONG_INTERVAL,
   input  wire logic        I_PULSE_INSTR,
   input  wire logic        I_PULSE_REP,
   // results and power
   output logic      [31:0] O_RESULT,
   output logic       [7:0] O_RESULT_LOC,
   output logic             O_RESULT_VALID,
   output logic             O_INSTR_BUSY,
   output logic             O_QUIESCENT_INHIBIT
);

   localparam logic [`PCA_DRAIN_W-1:0] DRAIN_LIM = 19'(DRAIN_FAST_CYC - 1);
   localparam logic [`PCA_DIV_W-1:0]   SLOW_LIM  = 3'(`PCA_DRAIN_FAST_HZ / `PCA_DRAIN_SLOW_HZ - 1);

   function automatic logic [16:0] sat_add16(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[16] ? {1'b1, 16'hffff} : s;
   endfunction : sat_add16

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // register file
   logic [1:0][31:0] cfg_r,  cfg_nxt;
   logic [1:0][15:0] mult_r, mult_nxt;
   logic [1:0][31:0] offs_r, offs_nxt;
   logic      [15:0] intv_r, intv_nxt;
   logic             ack_r,  ack_nxt;
   logic      [31:0] rdata_r, rdata_nxt;
   logic             req;
   logic             wr_en;

   // counting state
   logic [1:0][7:0]  cnt_r,  cnt_nxt;
   logic [1:0][15:0] acc_r,  acc_nxt;
   logic [1:0][15:0] snap_r, snap_nxt;
   logic      [1:0]  ovf_r,  ovf_nxt;
   logic [`PCA_DRAIN_W-1:0] fast_r, fast_nxt;
   logic [`PCA_DIV_W-1:0]   slow_r, slow_nxt;
   logic             tick64_r, tick64_nxt;
   logic             tick8_r,  tick8_nxt;
   logic      [3:0]  pin_r,  pin_nxt;
   logic             loc_sel_r, loc_sel_nxt;
   logic             quiet_r, quiet_nxt;

   // decode
   logic      [3:0]  pins;
   logic      [3:0]  raw_edge;
   logic      [3:0]  sw_evt;
   logic      [3:0]  open_evt;
   logic      [3:0]  close_evt;
   pca_type_t        ch_type [2];
   pca_opt_t         ch_opt  [2];
   logic      [1:0]  ch_sel  [2];
   logic      [1:0]  inc;
   logic      [1:0]  drain;
   logic             chain16;
   logic      [15:0] c16;
   logic      [15:0] dval;
   logic      [15:0] base;
   logic      [16:0] sum;
   logic             sc_start;
   logic             sc_busy;
   logic             sc_done;
   logic      [31:0] sc_result;

   assign pins = {I_SHARED_CONTROL_PULSE_PORT, I_CONTROL_PORT_ONE, I_PULSE_IN2, I_PULSE_IN1};

   // pulse pins idle high and close low; control ports idle low and close high
   pca_debounce #(.ACTIVE_CLOSED(1'b0), .CLOSE_QUAL(BOUNCE_CYC), .OPEN_QUAL(BOUNCE_CYC + 1)) u_db_p1 (
      .i_clk(I_REF_CLK), .i_rst_b(I_RST_B), .i_pin(I_PULSE_IN1),
      .o_open_evt(open_evt[0]), .o_close_evt(close_evt[0]));
   pca_debounce #(.ACTIVE_CLOSED(1'b0), .CLOSE_QUAL(BOUNCE_CYC), .OPEN_QUAL(BOUNCE_CYC + 1)) u_db_p2 (
      .i_clk(I_REF_CLK), .i_rst_b(I_RST_B), .i_pin(I_PULSE_IN2),
      .o_open_evt(open_evt[1]), .o_close_evt(close_evt[1]));
   pca_debounce #(.ACTIVE_CLOSED(1'b1), .CLOSE_QUAL(BOUNCE_CYC), .OPEN_QUAL(BOUNCE_CYC)) u_db_c1 (
      .i_clk(I_REF_CLK), .i_rst_b(I_RST_B), .i_pin(I_CONTROL_PORT_ONE),
      .o_open_evt(open_evt[2]), .o_close_evt(close_evt[2]));
   pca_debounce #(.ACTIVE_CLOSED(1'b1), .CLOSE_QUAL(BOUNCE_CYC), .OPEN_QUAL(BOUNCE_CYC)) u_db_c2 (
      .i_clk(I_REF_CLK), .i_rst_b(I_RST_B), .i_pin(I_SHARED_CONTROL_PULSE_PORT),
      .o_open_evt(open_evt[3]), .o_close_evt(close_evt[3]));

   assign sw_evt   = {close_evt[3:2], open_evt[1:0]};
   assign raw_edge = pins & ~pin_r;

   // channel decode
   always_comb begin
      chain16 = 1'b0;
      for (int c = 0; c < 2; c++) begin
         ch_type[c] = pca_type_t'(cfg_r[c][`PCA_F_TYPE]);
         ch_opt[c]  = pca_opt_t'(cfg_r[c][`PCA_F_OPT]);
         case (pca_src_t'(cfg_r[c][`PCA_F_SRC]))
            SRC_OWN_PIN:     ch_sel[c] = 2'(c);
            SRC_CTRL_ONE:    ch_sel[c] = 2'h2;
            default:         ch_sel[c] = 2'h3;
         endcase
         inc[c]   = (ch_type[c] == PT_SW) ? sw_evt[ch_sel[c]] : raw_edge[ch_sel[c]];
         drain[c] = (cfg_r[c][`PCA_F_INDEX] && ((ch_type[c] == PT_HF) || (ch_type[c] == PT_AC)))
                    ? tick64_r : tick8_r;
      end
      chain16 = (ch_type[0] == PT_HF16) || (ch_type[0] == PT_AC16);
   end

   // drain timebase: 64 Hz ticks, every eighth one is the 8 Hz drain
   always_comb begin
      fast_nxt   = 19'(fast_r + 1'b1);
      slow_nxt   = slow_r;
      tick64_nxt = 1'b0;
      tick8_nxt  = 1'b0;
      if (fast_r == DRAIN_LIM) begin
         fast_nxt   = '0;
         tick64_nxt = 1'b1;
         slow_nxt   = 3'(slow_r + 1'b1);
         tick8_nxt  = (slow_r == SLOW_LIM);
      end
   end

   // counters, accumulators and snapshots; a drain in the start cycle lands in the new interval
   always_comb begin
      cnt_nxt  = cnt_r;
      acc_nxt  = acc_r;
      snap_nxt = snap_r;
      ovf_nxt  = ovf_r;
      c16      = drain[0] ? '0 : {cnt_r[1], cnt_r[0]};
      dval     = '0;
      base     = '0;
      sum      = '0;
      if (chain16) begin
         if (inc[0] && (c16 != '1)) begin
            c16 = 16'(c16 + 1'b1);
         end
         cnt_nxt = {c16[15:8], c16[7:0]};
      end
      for (int c = 0; c < 2; c++) begin
         if (!chain16) begin
            cnt_nxt[c] = drain[c] ? '0 : cnt_r[c];
            if (inc[c] && (cnt_nxt[c] != '1)) begin
               cnt_nxt[c] = 8'(cnt_nxt[c] + 1'b1);
            end
         end
         if (I_TABLE_START) begin
            if (!((ch_opt[c] != OPT_NONE) && I_LONG_INTERVAL)) begin
               snap_nxt[c] = acc_r[c];
            end
         end
         base = I_TABLE_START ? '0 : acc_r[c];
         if (chain16) begin
            dval = (c == 0) ? {cnt_r[1], cnt_r[0]} : '0;
         end else begin
            dval = {8'h00, cnt_r[c]};
         end
         sum        = sat_add16(base, dval);
         acc_nxt[c] = drain[(chain16) ? 0 : c] ? sum[15:0] : base;
         ovf_nxt[c] = (I_TABLE_START ? 1'b0 : ovf_r[c]) | (drain[(chain16) ? 0 : c] & sum[16]);
      end
   end

   // instruction launch; a strobe while busy is dropped
   assign sc_start = I_PULSE_INSTR & ~sc_busy;

   always_comb begin
      loc_sel_nxt = sc_start ? I_PULSE_REP : loc_sel_r;
      quiet_nxt   = I_SHARED_CONTROL_PULSE_PORT & (I_SHARED_PORT_IRQ_EN |
                    (cfg_r[0][`PCA_F_SRC] >= SRC_SHARED_PORT) |
                    (cfg_r[1][`PCA_F_SRC] >= SRC_SHARED_PORT)); // source 2 and 3 both pick the shared port
   end

   pca_scale u_scale (
      .i_clk      (I_REF_CLK),
      .i_rst_b    (I_RST_B),
      .i_start    (sc_start),
      .i_count    (snap_r[I_PULSE_REP]),
      .i_freq     (ch_opt[sc_start ? I_PULSE_REP : loc_sel_r] == OPT_FREQ),
      .i_interval (intv_r),
      .i_mult     ($signed(mult_r[sc_start ? I_PULSE_REP : loc_sel_r])),
      .i_offset   ($signed(offs_r[sc_start ? I_PULSE_REP : loc_sel_r])),
      .o_busy     (sc_busy),
      .o_done     (sc_done),
      .o_result   (sc_result)
   );

   // avalon slave: one wait state, write lands at the accepting edge
   assign req               = I_AVS_READ | I_AVS_WRITE;
   assign wr_en             = I_AVS_WRITE & ack_r;
   assign O_AVS_WAITREQUEST = req & ~ack_r;

   always_comb begin
      ack_nxt   = req & ~ack_r;
      rdata_nxt = rdata_r;
      cfg_nxt   = cfg_r;
      mult_nxt  = mult_r;
      offs_nxt  = offs_r;
      intv_nxt  = intv_r;
      if (I_AVS_READ && !ack_r) begin
         if (I_AVS_ADDRESS == `PCA_REG_CFG0) rdata_nxt = cfg_r[0];
         else if (I_AVS_ADDRESS == `PCA_REG_CFG1) rdata_nxt = cfg_r[1];
         else if (I_AVS_ADDRESS == `PCA_REG_MULT0) rdata_nxt = {16'h0000, mult_r[0]};
         else if (I_AVS_ADDRESS == `PCA_REG_MULT1) rdata_nxt = {16'h0000, mult_r[1]};
         else if (I_AVS_ADDRESS == `PCA_REG_OFFS0) rdata_nxt = offs_r[0];
         else if (I_AVS_ADDRESS == `PCA_REG_OFFS1) rdata_nxt = offs_r[1];
         else if (I_AVS_ADDRESS == `PCA_REG_INTERVAL) rdata_nxt = {16'h0000, intv_r};
         else if (I_AVS_ADDRESS == `PCA_REG_STATUS) begin
            rdata_nxt = '0;
            rdata_nxt[`PCA_ST_OVF0]  = ovf_r[0];
            rdata_nxt[`PCA_ST_OVF1]  = ovf_r[1];
            rdata_nxt[`PCA_ST_BUSY]  = sc_busy;
            rdata_nxt[`PCA_ST_CHAIN] = chain16;
         end
         else if (I_AVS_ADDRESS == `PCA_REG_SNAP0) rdata_nxt = {16'h0000, snap_r[0]};
         else if (I_AVS_ADDRESS == `PCA_REG_SNAP1) rdata_nxt = {16'h0000, snap_r[1]};
         else if (I_AVS_ADDRESS == `PCA_REG_ACC0) rdata_nxt = {16'h0000, acc_r[0]};
         else if (I_AVS_ADDRESS == `PCA_REG_ACC1) rdata_nxt = {16'h0000, acc_r[1]};
         else if (I_AVS_ADDRESS == `PCA_REG_RESULT) rdata_nxt = sc_result;
         else rdata_nxt = '0;
      end
      if (wr_en) begin
         if (I_AVS_ADDRESS == `PCA_REG_CFG0) cfg_nxt[0] = be_merge(cfg_r[0], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
         else if (I_AVS_ADDRESS == `PCA_REG_CFG1) cfg_nxt[1] = be_merge(cfg_r[1], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
         else if (I_AVS_ADDRESS == `PCA_REG_MULT0)
            mult_nxt[0] = 16'(be_merge({16'h0000, mult_r[0]}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
         else if (I_AVS_ADDRESS == `PCA_REG_MULT1)
            mult_nxt[1] = 16'(be_merge({16'h0000, mult_r[1]}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
         else if (I_AVS_ADDRESS == `PCA_REG_OFFS0) offs_nxt[0] = be_merge(offs_r[0], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
         else if (I_AVS_ADDRESS == `PCA_REG_OFFS1) offs_nxt[1] = be_merge(offs_r[1], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
         else if (I_AVS_ADDRESS == `PCA_REG_INTERVAL)
            intv_nxt = 16'(be_merge({16'h0000, intv_r}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_B) begin
         cfg_r     <= {`PCA_CFG_RST, `PCA_CFG_RST};
         mult_r    <= {`PCA_MULT_RST, `PCA_MULT_RST};
         offs_r    <= {`PCA_OFFS_RST, `PCA_OFFS_RST};
         intv_r    <= `PCA_INTERVAL_RST;
         ack_r     <= 1'b0;
         rdata_r   <= '0;
         cnt_r     <= '0;
         acc_r     <= '0;
         snap_r    <= '0;
         ovf_r     <= '0;
         fast_r    <= '0;
         slow_r    <= '0;
         tick64_r  <= 1'b0;
         tick8_r   <= 1'b0;
         pin_r     <= pins; // follows the pins so idle-high pulse pins give no false edge after reset
         loc_sel_r <= 1'b0;
         quiet_r   <= 1'b0;
      end else begin
         cfg_r     <= cfg_nxt;
         mult_r    <= mult_nxt;
         offs_r    <= offs_nxt;
         intv_r    <= intv_nxt;
         ack_r     <= ack_nxt;
         rdata_r   <= rdata_nxt;
         cnt_r     <= cnt_nxt;
         acc_r     <= acc_nxt;
         snap_r    <= snap_nxt;
         ovf_r     <= ovf_nxt;
         fast_r    <= fast_nxt;
         slow_r    <= slow_nxt;
         tick64_r  <= tick64_nxt;
         tick8_r   <= tick8_nxt;
         pin_r     <= pins;
         loc_sel_r <= loc_sel_nxt;
         quiet_r   <= quiet_nxt;
      end
   end

   assign O_AVS_READDATA      = rdata_r;
   assign O_RESULT            = sc_result;
   assign O_RESULT_LOC        = cfg_r[loc_sel_r][`PCA_F_LOC];
   assign O_RESULT_VALID      = sc_done;
   assign O_INSTR_BUSY        = sc_busy;
   assign O_QUIESCENT_INHIBIT = quiet_r;

endmodule : pca_top

// [pca_asserts.sv]
/* port checker of the pulse count accumulator.
   assumes: bound to pca_top below; one clock, sync active low reset. */
`timescale 1ns/1ns
module pca_asserts (
   input wire logic        I_REF_CLK,
   input wire logic        I_RST_B,
   input wire logic        I_AVS_READ,
   input wire logic        O_AVS_WAITREQUEST,
   input wire logic        I_SHARED_CONTROL_PULSE_PORT,
   input wire logic        I_SHARED_PORT_IRQ_EN,
   input wire logic        I_PULSE_INSTR,
   input wire logic        O_INSTR_BUSY,
   input wire logic        O_RESULT_VALID,
   input wire logic [31:0] O_RESULT,
   input wire logic        O_QUIESCENT_INHIBIT
);
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_B);
   // exactly one wait state per request
   chk_wait_once: assert property (O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
      else $error("wait state too long");
   chk_wait_first: assert property ($rose(I_AVS_READ) |-> O_AVS_WAITREQUEST)
      else $error("read accepted with no wait state");
   chk_inhibit_set: assert property (I_SHARED_CONTROL_PULSE_PORT && I_SHARED_PORT_IRQ_EN |=> O_QUIESCENT_INHIBIT)
      else $error("quiescent entry not inhibited");
   chk_inhibit_low: assert property (!I_SHARED_CONTROL_PULSE_PORT |=> !O_QUIESCENT_INHIBIT)
      else $error("inhibit with shared port low");
   chk_instr_busy: assert property (I_PULSE_INSTR && !O_INSTR_BUSY |=> O_INSTR_BUSY)
      else $error("instruction not taken");
   chk_result_due: assert property (I_PULSE_INSTR && !O_INSTR_BUSY |-> ##[2:18] O_RESULT_VALID)
      else $error("result late");
   chk_valid_pulse: assert property (O_RESULT_VALID |-> $past(O_INSTR_BUSY) ##1 !O_RESULT_VALID)
      else $error("result valid without busy or too long");
   chk_result_hold: assert property ($changed(O_RESULT) |-> O_RESULT_VALID)
      else $error("result changed without valid");
endmodule : pca_asserts
bind pca_top pca_asserts chk_u (.*);

// [pca_sensor.sv]
/* switch and pulse source on the pins: 0,1 pulse pins, 2 port one, 3 shared.
   assumes: tb calls burst; pulse pins idle high (pull-up), ports idle low. */
`timescale 1ns/1ns
module pca_sensor (
   input  wire logic       i_clk,
   output logic      [3:0] o_pin
);
   initial o_pin = 4'h3;
   task burst(input int p, input int n, input int w);
      logic idl;
      idl = (p < 2);
      repeat (n) begin
         @(posedge i_clk) o_pin[p] <= ~idl;
         repeat (w) @(posedge i_clk);
         if (w > 4) begin // bounce shorter than the filter window
            o_pin[p] <= idl;
            repeat (2) @(posedge i_clk);
            o_pin[p] <= ~idl;
            repeat (w) @(posedge i_clk);
         end
         o_pin[p] <= idl; // back to idle: opening on pins and ports alike
         repeat (w) @(posedge i_clk);
      end
   endtask : burst
endmodule : pca_sensor

// [tb_top.sv]
/* self-checking bench of pca_top with the pin model.
   assumes: short bounce and drain counts set at the instance. */
`timescale 1ns/1ns
module tb_top;
   logic        clk, rst_b, rd, wr, tst, lng, ins, irq, wq, vld, bsy, inh, rep;
   logic [5:0]  addr;
   logic [31:0] wdata, q, rdat, res, expv, o;
   logic [3:0]  pin;
   logic [7:0]  loc;
   logic [15:0] m;
   logic [2:0]  ty [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h2, 3'h2};
   int          seed = 91, miscompares = 0, total_checks = 0, cyc = 0, n;
   pca_sensor snr_u (.i_clk(clk), .o_pin(pin));
   pca_top #(.BOUNCE_CYC(4), .DRAIN_FAST_CYC(64)) dut_u (.I_REF_CLK(clk), .I_RST_B(rst_b),
      .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
      .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wq), .I_PULSE_IN1(pin[0]),
      .I_PULSE_IN2(pin[1]), .I_CONTROL_PORT_ONE(pin[2]), .I_SHARED_CONTROL_PULSE_PORT(pin[3]),
      .I_SHARED_PORT_IRQ_EN(irq), .I_TABLE_START(tst), .I_LONG_INTERVAL(lng), .I_PULSE_INSTR(ins),
      .I_PULSE_REP(rep), .O_RESULT(res), .O_RESULT_LOC(loc), .O_RESULT_VALID(vld),
      .O_INSTR_BUSY(bsy), .O_QUIESCENT_INHIBIT(inh));
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   task complete_run;
      if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         complete_run;
      end
   end
   task check(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      rd <= ~w;
      wr <= w;
      do @(posedge clk); while (wq !== 1'b0);
      q = rdat;
      rd <= 0;
      wr <= 0;
   endtask : bus
   // table start, then instruction; result checked when valid comes
   task run(input logic l, input logic [7:0] el);
      @(posedge clk) tst <= 1;
      lng <= l;
      @(posedge clk) tst <= 0;
      ins <= 1;
      @(posedge clk) ins <= 0;
      do @(posedge clk); while (vld !== 1'b1);
      check(res, expv);
      check({24'h0, loc}, {24'h0, el});
   endtask : run
   function automatic logic [31:0] exp_res(input int c, input logic signed [15:0] mm, input logic [31:0] oo);
      return c * mm + $signed(oo);
   endfunction : exp_res
   initial begin
      {rst_b, rd, wr, tst, lng, ins, irq, rep, addr, wdata} = '0;
      repeat (12) @(posedge clk);
      rst_b <= 1;
      bus(0, 6'h08, 0);
      check(q, 32'h1);
      bus(1, 6'h3c, 32'hffff_ffff);
      bus(0, 6'h3c, 0);
      check(q, 32'h0);
      irq <= 1;
      snr_u.burst(3, 2, 2);
      irq <= 0;
      for (int i = 0; i < 6; i++) begin // every input type
         n = 1 + {$random(seed)} % 6;
         m = 16'($random(seed));
         o = $random(seed);
         bus(1, 6'h00, {16'h0, 8'h40 + 8'(i), (i == 5) ? 2'h1 : 2'h0, 1'b1, 2'h0, ty[i]});
         bus(1, 6'h08, {16'h0, m});
         bus(1, 6'h10, o);
         snr_u.burst((i == 5) ? 2 : 0, n, (ty[i] == 3'h2) ? 6 : 2);
         repeat (600) @(posedge clk); // slowest drain is 512 cycles
         expv = exp_res(n, m, o);
         run(0, 8'h40 + 8'(i));
      end
      bus(1, 6'h00, 32'h0000_5028);
      snr_u.burst(0, 3, 2);
      repeat (600) @(posedge clk);
      run(1, 8'h50); // previous snapshot kept
      bus(1, 6'h18, 32'h2);
      bus(1, 6'h00, 32'h0000_5030);
      snr_u.burst(0, 6, 2);
      repeat (600) @(posedge clk);
      expv = exp_res(3, m, o);
      run(0, 8'h50);
      rep <= 1;
      bus(1, 6'h04, 32'h0000_6020);
      bus(1, 6'h0c, {16'h0, m});
      bus(1, 6'h14, o);
      snr_u.burst(1, 5, 2);
      repeat (600) @(posedge clk);
      expv = exp_res(5, m, o);
      run(0, 8'h60); // second repetition keeps its own store
      complete_run;
   end
endmodule : tb_top
